//--- core/base_regs_pkg.sv
// constants, types and helpers of the base register file
// Notes on behaviour
// RULE_01 - eight 32-bit registers; word writes keep upper
// RULE_02 - byte views on first four; not addresses; the read port gives byte views of all eight
// RULE_03 - pointer holds next offset; low half 16-bit
// RULE_04 - saved word: bit1 one, reserved bits zero
// RULE_05 - alignment faults only at privilege three
// RULE_06 - misaligned: odd word, dword, qword boundaries
// RULE_07 - alignment fault vector 17, error code zero
// RULE_08 - descriptor and task record references never fault
// RULE_09 - virtual mode faults privileged opcodes with 13
// RULE_10 - virtual bit: return at zero or task
// RULE_11 - resume flag masks debug fault, then clears
// RULE_12 - nested task bit steers interrupt return
// RULE_13 - io field bounds direct io and irq-enable
// RULE_14 - io field changes at zero or task
// RULE_15 - overflow: carry into sign differs from out
// RULE_16 - direction bit: string indexes up or down
// RULE_17 - irq pin recognised only while enabled
// RULE_18 - single step traps after next instruction
// RULE_19 - sign copies top bit; zero flags zero
// RULE_20 - half carry from bit three, any size
// RULE_21 - parity even over low byte only
// RULE_22 - carry out of top bit sets carry
package base_regs_pkg;
	// status word bit positions
	localparam int BIT_CARRY  = 0;
	localparam int BIT_PARITY = 2;
	localparam int BIT_HALF   = 4;
	localparam int BIT_ZERO   = 6;
	localparam int BIT_SIGN   = 7;
	localparam int BIT_STEP   = 8;
	localparam int BIT_IF     = 9;
	localparam int BIT_DIR    = 10;
	localparam int BIT_OVF    = 11;
	localparam int BIT_IOPRIV = 12;
	localparam int BIT_NEST   = 14;
	localparam int BIT_RESUME = 16;
	localparam int BIT_VIRT   = 17;
	localparam int BIT_ALIGN  = 18;
	// masks over the status word
	localparam logic [31:0] SAVE_ZERO_MASK = 32'hFFF8_8028;
	localparam logic [31:0] SAVE_ONE_MASK  = 32'h0000_0002;
	localparam logic [31:0] LOADABLE_MASK  = 32'h0007_7FD5;
	localparam logic [31:0] ARITH_MASK     = 32'h0000_08D5;
	localparam logic [31:0] MASK_VIRT      = 32'h1 << BIT_VIRT;
	localparam logic [31:0] MASK_IF        = 32'h1 << BIT_IF;
	localparam logic [31:0] MASK_IOPRIV    = 32'h3 << BIT_IOPRIV;
	// reset values
	localparam logic [31:0] SCW_RESET      = 32'h0000_0002;
	localparam logic [31:0] GPR_RESET      = 32'h0000_0000;
	localparam logic [31:0] PTR_RESET      = 32'h0000_0000;
	// register indexes of the string pointers
	localparam logic [2:0]  SRC_IDX        = 3'h6;
	localparam logic [2:0]  DST_IDX        = 3'h7;
	// privilege levels and fault codes
	localparam logic [1:0]  PL_KERNEL      = 2'h0;
	localparam logic [1:0]  PL_USER        = 2'h3;
	localparam logic [7:0]  VEC_DEBUG      = 8'h01;
	localparam logic [7:0]  VEC_GP         = 8'h0D;
	localparam logic [7:0]  VEC_ALIGN      = 8'h11;
	localparam logic [31:0] ALIGN_ERR_CODE = 32'h0000_0000;

	// register views
	typedef enum logic [1:0] {
		VIEW_BYTE_LO = 2'b00,
		VIEW_BYTE_HI = 2'b01,
		VIEW_WORD    = 2'b10,
		VIEW_DWORD   = 2'b11
	} view_t;
	// operand sizes
	typedef enum logic [1:0] {
		OP8  = 2'b00,
		OP16 = 2'b01,
		OP32 = 2'b10
	} opsize_t;
	// memory reference sizes
	typedef enum logic [1:0] {
		MEM_BYTE  = 2'b00,
		MEM_WORD  = 2'b01,
		MEM_DWORD = 2'b10,
		MEM_QWORD = 2'b11
	} mem_size_t;
	// status word operations
	typedef enum logic [2:0] {
		FOP_NONE = 3'b000,
		FOP_POP  = 3'b001,
		FOP_RET  = 3'b010,
		FOP_TASK = 3'b011,
		FOP_PUSH = 3'b100,
		FOP_INT  = 3'b101
	} flag_op_t;

	// stored image: fixed bits forced, virtual bit kept only when asked
	function automatic logic [31:0] save_image(input logic [31:0] w, input logic keep_virt);
		logic [31:0] r;
		r = (w & ~SAVE_ZERO_MASK) | SAVE_ONE_MASK;
		r[BIT_VIRT] = keep_virt & w[BIT_VIRT];
		return r;
	endfunction : save_image

	// misalignment test on the low address bits
	function automatic logic misaligned(input mem_size_t s, input logic [2:0] a);
		case (s) // see RULE_06
			MEM_WORD:  return a[0];
			MEM_DWORD: return |a[1:0];
			MEM_QWORD: return |a;
			default:   return 1'b0;
		endcase
	endfunction : misaligned

	// write data through a view, untouched bits kept
	function automatic logic [31:0] merge_view(input logic [31:0] old, input view_t v,
		input logic [31:0] d);
		case (v)
			VIEW_BYTE_LO: return {old[31:8], d[7:0]};
			VIEW_BYTE_HI: return {old[31:16], d[7:0], old[7:0]};
			VIEW_WORD:    return {old[31:16], d[15:0]};
			default:      return d;
		endcase
	endfunction : merge_view

	// read a view, zero extended
	function automatic logic [31:0] read_view(input logic [31:0] w, input view_t v);
		case (v)
			VIEW_BYTE_LO: return {24'h0, w[7:0]};
			VIEW_BYTE_HI: return {24'h0, w[15:8]};
			VIEW_WORD:    return {16'h0, w[15:0]};
			default:      return w;
		endcase
	endfunction : read_view
endpackage : base_regs_pkg

//--- core/flag_alu.sv
// adder with arithmetic status flag generation
`timescale 1ns/1ps
module flag_alu (
	// operands
	input  wire logic                    [31:0] a,
	input  wire logic                    [31:0] b,
	input  wire logic                           sub,
	input  wire base_regs_pkg::opsize_t         size,
	// result and flags at their status word positions
	output logic                         [31:0] result,
	output logic                         [31:0] flags
);
	logic [32:0] sum;   // full width sum or difference
	logic [32:0] cin;   // carry or borrow into each bit
	logic [31:0] res_m; // result cut to operand size
	logic        top;   // carry into sign bit
	logic        out;   // carry out of sign bit

	// flag equations
	always_comb begin
		sum = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
		cin = {1'b0, a} ^ {1'b0, b} ^ sum;
		case (size)
			base_regs_pkg::OP8: begin
				res_m = {24'h0, sum[7:0]};
				top   = cin[7];
				out   = cin[8];
			end
			base_regs_pkg::OP16: begin
				res_m = {16'h0, sum[15:0]};
				top   = cin[15];
				out   = cin[16];
			end
			default: begin
				res_m = sum[31:0];
				top   = cin[31];
				out   = cin[32];
			end
		endcase
		result = res_m;
		flags  = 32'h0;
		flags[base_regs_pkg::BIT_CARRY]  = out;              // see RULE_22
		flags[base_regs_pkg::BIT_OVF]    = top ^ out;        // see RULE_15
		flags[base_regs_pkg::BIT_HALF]   = cin[4];           // see RULE_20
		flags[base_regs_pkg::BIT_PARITY] = ~^res_m[7:0];     // see RULE_21
		flags[base_regs_pkg::BIT_ZERO]   = (res_m == 32'h0); // see RULE_19
		flags[base_regs_pkg::BIT_SIGN]   = (size == base_regs_pkg::OP8) ? res_m[7] :
			(size == base_regs_pkg::OP16) ? res_m[15] : res_m[31]; // see RULE_19
	end
endmodule : flag_alu

//--- core/base_register_file.sv
// base register file: general registers, pointer and status word
`timescale 1ns/1ps
module base_register_file (
	// clock, reset and enable
	input  wire logic                           clock,
	input  wire logic                           rstn,
	input  wire logic                           clk_en,
	// general register write port
	input  wire logic                           gpr_wr_en,
	input  wire logic                    [2:0]  gpr_wr_sel,
	input  wire base_regs_pkg::view_t           gpr_wr_view,
	input  wire logic                    [31:0] gpr_wr_data,
	// general register read port
	input  wire logic                    [2:0]  gpr_rd_sel,
	input  wire base_regs_pkg::view_t           gpr_rd_view,
	output logic                         [31:0] gpr_rd_data,
	// address operand read port
	input  wire logic                    [2:0]  addr_sel,
	input  wire logic                           addr_wide,
	output logic                         [31:0] addr_data,
	// string index stepping
	input  wire logic                           string_step,
	input  wire base_regs_pkg::opsize_t         string_size,
	// arithmetic operation
	input  wire logic                           alu_valid,
	input  wire logic                           alu_sub,
	input  wire base_regs_pkg::opsize_t         alu_size,
	input  wire logic                    [31:0] alu_a,
	input  wire logic                    [31:0] alu_b,
	output logic                         [31:0] alu_result,
	// instruction retire and pointer
	input  wire logic                           instr_done,
	input  wire logic                    [3:0]  instr_len,
	input  wire logic                           ip_load,
	input  wire logic                    [31:0] ip_target,
	output logic                         [31:0] next_instr_pointer,
	output logic                         [15:0] next_instr_offset16,
	// status word operations
	input  wire base_regs_pkg::flag_op_t        flag_op,
	input  wire logic                    [31:0] flag_image,
	input  wire logic                    [1:0]  current_privilege_level,
	input  wire logic                           protected_mode,
	output logic                         [31:0] status_control_word,
	output logic                         [31:0] saved_image,
	output logic                                saved_valid,
	output logic                                ret_to_task,
	// memory reference check
	input  wire logic                           mem_valid,
	input  wire base_regs_pkg::mem_size_t       mem_size,
	input  wire logic                    [2:0]  mem_addr,
	input  wire logic                           mem_sys_ref,
	// privilege and debug checks
	input  wire logic                           priv_op_valid,
	input  wire logic                           bp_hit,
	output logic                                io_direct_ok,
	// fault report
	output logic                                fault_valid,
	output logic                         [7:0]  fault_vector,
	output logic                         [31:0] fault_code,
	// maskable interrupt
	input  wire logic                           maskable_irq_pin,
	output logic                                irq_accept
);
	////////////////////////////////////////////////////////////////////////////////
	// general registers

	logic [31:0] gpr      [8]; // register array
	logic [31:0] next_gpr [8]; // next register array
	logic [31:0] step_bytes;   // string element size in bytes
	logic [31:0] step_delta;   // signed index step
	logic        byte_ok;      // write view exists for the target

	// next register values: string step first, explicit write wins
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			next_gpr[i] = gpr[i];
		end
		step_bytes = 32'h1 << string_size;
		step_delta = status_control_word[base_regs_pkg::BIT_DIR] ?
			-step_bytes : step_bytes; // see RULE_16
		if (string_step) begin
			next_gpr[base_regs_pkg::SRC_IDX] = gpr[base_regs_pkg::SRC_IDX] + step_delta;
			next_gpr[base_regs_pkg::DST_IDX] = gpr[base_regs_pkg::DST_IDX] + step_delta;
		end
		// byte views only on the first four registers
		byte_ok = gpr_wr_view[1] || !gpr_wr_sel[2]; // see RULE_02
		if (gpr_wr_en && byte_ok) begin
			next_gpr[gpr_wr_sel] = base_regs_pkg::merge_view(gpr[gpr_wr_sel],
				gpr_wr_view, gpr_wr_data); // see RULE_01
		end
	end

	// register array storage
	always_ff @(posedge clock) begin
		if (!rstn) begin
			for (int i = 0; i < 8; i++) begin
				gpr[i] <= base_regs_pkg::GPR_RESET;
			end
		end else if (clk_en) begin
			gpr <= next_gpr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// arithmetic unit

	logic [31:0] alu_sum;   // combinational result
	logic [31:0] alu_flags; // flags at word positions

	flag_alu u_flag_alu (
		.a      (alu_a),
		.b      (alu_b),
		.sub    (alu_sub),
		.size   (alu_size),
		.result (alu_sum),
		.flags  (alu_flags)
	);

	////////////////////////////////////////////////////////////////////////////////
	// status word, pointer, checks and faults

	logic [31:0] next_scw;       // next status word
	logic [31:0] next_ptr;       // next instruction pointer
	logic [31:0] next_rd;        // next read data
	logic [31:0] next_addr;      // next address operand
	logic [31:0] next_alu;       // next stored result
	logic [31:0] next_saved;     // next saved image
	logic        next_saved_v;   // next saved strobe
	logic        next_ret_task;  // next return kind
	logic        next_io_ok;     // next io permission
	logic        next_fault;     // next fault strobe
	logic [7:0]  next_vector;    // next fault vector
	logic [31:0] next_code;      // next error code
	logic        next_irq;       // next interrupt accept
	logic        next_irq_lvl;   // next filtered pin level
	logic [31:0] load_mask;      // bits an image may load
	logic [1:0]  io_priv;        // current io privilege field
	logic        align_hit;      // alignment fault this cycle
	logic        gp_hit;         // privileged opcode fault
	logic        dbg_hit;        // debug fault or step trap
	logic        irq_s1;         // pin sync stage 1
	logic        irq_s2;         // pin sync stage 2
	logic        irq_s3;         // pin sync stage 3
	logic        irq_lvl;        // agreed pin level

	assign io_priv = status_control_word[base_regs_pkg::BIT_IOPRIV +: 2];

	// next values of the status, pointer and event group
	always_comb begin
		next_scw = status_control_word;
		// arithmetic flags from the operation
		if (alu_valid) begin
			next_scw = (next_scw & ~base_regs_pkg::ARITH_MASK) |
				(alu_flags & base_regs_pkg::ARITH_MASK); // see RULE_19
		end
		// which bits an image may load
		load_mask = base_regs_pkg::LOADABLE_MASK;
		case (flag_op)
			base_regs_pkg::FOP_POP: begin
				load_mask &= ~base_regs_pkg::MASK_VIRT; // see RULE_10
				if (current_privilege_level != base_regs_pkg::PL_KERNEL) begin
					load_mask &= ~base_regs_pkg::MASK_IOPRIV; // see RULE_14
				end
				if (current_privilege_level > io_priv) begin
					load_mask &= ~base_regs_pkg::MASK_IF; // see RULE_13
				end
			end
			base_regs_pkg::FOP_RET: begin
				if (current_privilege_level != base_regs_pkg::PL_KERNEL || !protected_mode) begin
					load_mask &= ~(base_regs_pkg::MASK_VIRT | base_regs_pkg::MASK_IOPRIV); // see RULE_10
				end
				if (current_privilege_level > io_priv) begin
					load_mask &= ~base_regs_pkg::MASK_IF; // see RULE_13
				end
			end
			base_regs_pkg::FOP_TASK: begin
				load_mask = base_regs_pkg::LOADABLE_MASK; // see RULE_14
			end
			default: begin
				load_mask = 32'h0;
			end
		endcase
		// image load covers resume and nested task bits too
		next_scw = (next_scw & ~load_mask) | (flag_image & load_mask); // see RULE_12
		// resume flag ends with a retired instruction free of debug faults and image loads
		dbg_hit = (bp_hit && !status_control_word[base_regs_pkg::BIT_RESUME]) ||
			(instr_done && status_control_word[base_regs_pkg::BIT_STEP]); // see RULE_18
		if (instr_done && !dbg_hit && load_mask == 32'h0) begin
			next_scw[base_regs_pkg::BIT_RESUME] = 1'b0; // see RULE_11
		end
		// saved images for push and interrupt entry
		next_saved_v = 1'b0;
		next_saved   = saved_image;
		if (flag_op == base_regs_pkg::FOP_PUSH) begin
			next_saved   = base_regs_pkg::save_image(status_control_word, 1'b0); // see RULE_10
			next_saved_v = 1'b1;
		end else if (flag_op == base_regs_pkg::FOP_INT) begin
			next_saved   = base_regs_pkg::save_image(status_control_word, 1'b1); // see RULE_04
			next_saved_v = 1'b1;
		end
		// return kind sampled from the pre-load nested bit
		next_ret_task = ret_to_task;
		if (flag_op == base_regs_pkg::FOP_RET) begin
			next_ret_task = status_control_word[base_regs_pkg::BIT_NEST]; // see RULE_12
		end
		// instruction pointer
		next_ptr = next_instr_pointer;
		if (ip_load) begin
			next_ptr = ip_target;
		end else if (instr_done) begin
			next_ptr = next_instr_pointer + 32'(instr_len); // see RULE_03
		end
		// read ports; address port has no byte views
		next_rd   = base_regs_pkg::read_view(gpr[gpr_rd_sel], gpr_rd_view);
		next_addr = addr_wide ? gpr[addr_sel] : {16'h0, gpr[addr_sel][15:0]}; // see RULE_02
		next_alu  = alu_valid ? alu_sum : alu_result;
		next_io_ok = (current_privilege_level <= io_priv); // see RULE_13
		// fault sources, alignment first; system references count as level zero
		align_hit = mem_valid && !mem_sys_ref && // see RULE_08
			status_control_word[base_regs_pkg::BIT_ALIGN] &&
			current_privilege_level == base_regs_pkg::PL_USER &&
			base_regs_pkg::misaligned(mem_size, mem_addr); // see RULE_05
		gp_hit  = priv_op_valid && protected_mode &&
			status_control_word[base_regs_pkg::BIT_VIRT]; // see RULE_09
		next_fault  = align_hit || gp_hit || dbg_hit;
		next_vector = fault_vector;
		next_code   = fault_code;
		if (align_hit) begin
			next_vector = base_regs_pkg::VEC_ALIGN; // see RULE_07
			next_code   = base_regs_pkg::ALIGN_ERR_CODE;
		end else if (gp_hit) begin
			next_vector = base_regs_pkg::VEC_GP;
			next_code   = 32'h0;
		end else if (dbg_hit) begin
			next_vector = base_regs_pkg::VEC_DEBUG;
			next_code   = 32'h0;
		end
		// pin level changes once stages two and three agree
		next_irq_lvl = (irq_s2 == irq_s3) ? irq_s3 : irq_lvl;
		next_irq     = irq_lvl && status_control_word[base_regs_pkg::BIT_IF]; // see RULE_17
	end

	// status, pointer and event registers
	always_ff @(posedge clock) begin
		if (!rstn) begin
			status_control_word <= base_regs_pkg::SCW_RESET;
			next_instr_pointer  <= base_regs_pkg::PTR_RESET;
			next_instr_offset16 <= base_regs_pkg::PTR_RESET[15:0];
			gpr_rd_data         <= 32'h0;
			addr_data           <= 32'h0;
			alu_result          <= 32'h0;
			saved_image         <= 32'h0;
			saved_valid         <= 1'b0;
			ret_to_task         <= 1'b0;
			io_direct_ok        <= 1'b0;
			fault_valid         <= 1'b0;
			fault_vector        <= 8'h00;
			fault_code          <= 32'h0;
			irq_accept          <= 1'b0;
			irq_s1              <= 1'b0;
			irq_s2              <= 1'b0;
			irq_s3              <= 1'b0;
			irq_lvl             <= 1'b0;
		end else if (clk_en) begin
			status_control_word <= next_scw;
			next_instr_pointer  <= next_ptr;
			next_instr_offset16 <= next_ptr[15:0]; // see RULE_03
			gpr_rd_data         <= next_rd;
			addr_data           <= next_addr;
			alu_result          <= next_alu;
			saved_image         <= next_saved;
			saved_valid         <= next_saved_v;
			ret_to_task         <= next_ret_task;
			io_direct_ok        <= next_io_ok;
			fault_valid         <= next_fault;
			fault_vector        <= next_vector;
			fault_code          <= next_code;
			irq_accept          <= next_irq;
			irq_s1              <= maskable_irq_pin;
			irq_s2              <= irq_s1;
			irq_s3              <= irq_s2;
			irq_lvl             <= next_irq_lvl;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	logic [15:0] wr_upper; // upper half of the write target
	assign wr_upper = gpr[gpr_wr_sel][31:16];

	AST_WORD_KEEPS_UPPER: // see RULE_01
	assert property (clk_en && gpr_wr_en && gpr_wr_view == base_regs_pkg::VIEW_WORD
		|=> gpr[$past(gpr_wr_sel)][31:16] == $past(wr_upper))
		else $error("word write changed upper half");
	AST_SAVED_FIXED_BITS: // see RULE_04
	assert property (saved_valid |-> saved_image[1] &&
		(saved_image & base_regs_pkg::SAVE_ZERO_MASK) == 32'h0)
		else $error("saved image fixed bits wrong");
	AST_ALIGN_FAULT: // see RULE_07
	assert property (clk_en && mem_valid && !mem_sys_ref && status_control_word[18] &&
		current_privilege_level == 2'h3 && mem_size == base_regs_pkg::MEM_WORD && mem_addr[0]
		|=> fault_valid && fault_vector == 8'h11 && fault_code == 32'h0)
		else $error("misaligned user word did not fault");
	AST_NO_ALIGN_LOW_PL: // see RULE_05
	assert property (fault_valid && fault_vector == 8'h11
		|-> $past(current_privilege_level) == 2'h3 && !$past(mem_sys_ref))
		else $error("alignment fault outside user level");
	AST_POP_KEEPS_VIRT: // see RULE_10
	assert property (clk_en && flag_op == base_regs_pkg::FOP_POP
		|=> $stable(status_control_word[17]))
		else $error("pop changed virtual mode bit");
	AST_POP_IOPRIV_GUARD: // see RULE_14
	assert property (clk_en && flag_op == base_regs_pkg::FOP_POP && current_privilege_level != 2'h0
		|=> $stable(io_priv))
		else $error("io field changed above level zero");
	AST_RESUME_CLEARS: // see RULE_11
	assert property (clk_en && instr_done && flag_op == base_regs_pkg::FOP_NONE && !bp_hit &&
		!status_control_word[8] |=> !status_control_word[16])
		else $error("resume flag not cleared");
	AST_IRQ_MASKED: // see RULE_17
	assert property (irq_accept |-> $past(status_control_word[9]))
		else $error("irq accepted while disabled");
	AST_STEP_SOURCE: // see RULE_18
	assert property (fault_valid && fault_vector == 8'h01
		|-> $past(status_control_word[8]) || $past(bp_hit))
		else $error("debug trap without cause");
	AST_OVERFLOW_8: // see RULE_15
	assert property (clk_en && alu_valid && !alu_sub && alu_size == base_regs_pkg::OP8 &&
		alu_a[7:0] == 8'h7F && alu_b[7:0] == 8'h01
		|=> status_control_word[11] && status_control_word[7] && !status_control_word[0])
		else $error("byte overflow flags wrong");

	COV_ALIGN: cover property (fault_valid && fault_vector == 8'h11);
	COV_IRQ:   cover property (irq_accept);
	COV_PUSH:  cover property (saved_valid ##1 flag_op == base_regs_pkg::FOP_POP);
endmodule : base_register_file

//--- sim/base_register_file_test.sv
// self-checking bench of the base register file
`timescale 1ns/1ps
module base_register_file_test;
	////////////////////////////////////////////////////////////////////////////////
	// stimulus and observed signals, stimulus set at time zero
	logic clock = 1'b0, rstn = 1'b0, clk_en = 1'b1, gpr_wr_en = 1'b0, addr_wide = 1'b0;
	logic string_step = 1'b0, alu_valid = 1'b0, alu_sub = 1'b0, instr_done = 1'b0;
	logic ip_load = 1'b0, protected_mode = 1'b1, mem_valid = 1'b0, mem_sys_ref = 1'b0;
	logic priv_op_valid = 1'b0, bp_hit = 1'b0, maskable_irq_pin = 1'b0;
	logic [2:0] gpr_wr_sel = 3'h0, gpr_rd_sel = 3'h0, addr_sel = 3'h0, mem_addr = 3'h0;
	logic [3:0] instr_len = 4'h0;
	logic [1:0] current_privilege_level = 2'h0;
	logic [31:0] gpr_wr_data = 32'h0, alu_a = 32'h0, alu_b = 32'h0, ip_target = 32'h0;
	logic [31:0] flag_image = 32'h0;
	base_regs_pkg::view_t gpr_wr_view = base_regs_pkg::VIEW_DWORD;
	base_regs_pkg::view_t gpr_rd_view = base_regs_pkg::VIEW_DWORD;
	base_regs_pkg::opsize_t string_size = base_regs_pkg::OP8, alu_size = base_regs_pkg::OP8;
	base_regs_pkg::flag_op_t flag_op = base_regs_pkg::FOP_NONE;
	base_regs_pkg::mem_size_t mem_size = base_regs_pkg::MEM_BYTE;
	logic [31:0] gpr_rd_data, addr_data, alu_result, next_instr_pointer, status_control_word;
	logic [31:0] saved_image, fault_code;
	logic [15:0] next_instr_offset16;
	logic [7:0] fault_vector;
	logic saved_valid, ret_to_task, io_direct_ok, fault_valid, irq_accept;
	int mismatches = 0, samples_checked = 0, cycles = 0;

	base_register_file dut_u (.*);

	// 10 MHz clock and a cycle ceiling against hangs
	always #50 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic tick(input int n = 1);
		repeat (n) @(posedge clock);
	endtask : tick
	// take the operation, release the strobes, look one edge later
	task automatic fire;
		tick();
		gpr_wr_en <= 1'b0;
		string_step <= 1'b0;
		alu_valid <= 1'b0;
		instr_done <= 1'b0;
		ip_load <= 1'b0;
		flag_op <= base_regs_pkg::FOP_NONE;
		mem_valid <= 1'b0;
		priv_op_valid <= 1'b0;
		bp_hit <= 1'b0;
		tick();
	endtask : fire
	task automatic expect32(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : expect32
	task automatic wr(input logic [2:0] s, input base_regs_pkg::view_t v, input logic [31:0] d);
		gpr_wr_en <= 1'b1;
		gpr_wr_sel <= s;
		gpr_wr_view <= v;
		gpr_wr_data <= d;
		fire();
	endtask : wr
	task automatic rd(input logic [2:0] s, input logic [31:0] exp);
		gpr_rd_sel <= s;
		fire();
		expect32(gpr_rd_data, exp);
	endtask : rd
	task automatic alu(input logic s, input base_regs_pkg::opsize_t z, input logic [31:0] a, b,
		input logic [31:0] exp);
		alu_valid <= 1'b1;
		alu_sub <= s;
		alu_size <= z;
		alu_a <= a;
		alu_b <= b;
		fire();
		expect32(status_control_word, exp);
	endtask : alu
	task automatic fl(input base_regs_pkg::flag_op_t o, input logic [1:0] p, input logic [31:0] i);
		flag_op <= o;
		current_privilege_level <= p;
		flag_image <= i;
		fire();
	endtask : fl
	task automatic mref(input base_regs_pkg::mem_size_t s, input logic [2:0] a, input logic y,
		input logic [1:0] p, input logic f);
		mem_valid <= 1'b1;
		mem_size <= s;
		mem_addr <= a;
		mem_sys_ref <= y;
		current_privilege_level <= p;
		fire();
		expect32({31'h0, fault_valid}, {31'h0, f});
		if (f)
			expect32({fault_vector, fault_code[23:0]}, 32'h1100_0000);
	endtask : mref

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic s_regs;
		maskable_irq_pin <= 1'b1;
		wr(3'h0, base_regs_pkg::VIEW_DWORD, 32'hAABB_CCDD);
		wr(3'h0, base_regs_pkg::VIEW_WORD, 32'hFFFF_1234);
		wr(3'h0, base_regs_pkg::VIEW_BYTE_HI, 32'hFFFF_FF56);
		rd(3'h0, 32'hAABB_5634);
		wr(3'h4, base_regs_pkg::VIEW_DWORD, 32'h1111_1111);
		wr(3'h4, base_regs_pkg::VIEW_BYTE_LO, 32'h0000_0022);
		rd(3'h4, 32'h1111_1111);
		clk_en <= 1'b0;
		wr(3'h4, base_regs_pkg::VIEW_DWORD, 32'h0);
		clk_en <= 1'b1;
		rd(3'h4, 32'h1111_1111);
		expect32(addr_data, 32'h0000_5634);
		string_step <= 1'b1;
		string_size <= base_regs_pkg::OP16;
		fire();
		rd(3'h7, 32'h0000_0002);
		ip_load <= 1'b1;
		ip_target <= 32'h0001_FFFE;
		fire();
		instr_done <= 1'b1;
		instr_len <= 4'h5;
		fire();
		expect32(next_instr_pointer, 32'h0002_0003);
		expect32({16'h0, next_instr_offset16}, 32'h0000_0003);
		expect32({31'h0, irq_accept}, 32'h0);
	endtask : s_regs
	task automatic s_flags;
		alu(1'b0, base_regs_pkg::OP8, 32'h0000_007F, 32'h1, 32'h0000_0892);
		alu(1'b0, base_regs_pkg::OP8, 32'h0000_00FF, 32'h1, 32'h0000_0057);
		alu(1'b1, base_regs_pkg::OP16, 32'h0, 32'h1, 32'h0000_0097);
		alu(1'b0, base_regs_pkg::OP32, 32'h7FFF_FFFF, 32'h1, 32'h0000_0896);
		expect32(alu_result, 32'h8000_0000);
	endtask : s_flags
	task automatic s_image;
		fl(base_regs_pkg::FOP_POP, 2'h3, 32'hFFFF_FFFF);
		expect32(status_control_word, 32'h0005_4DD7);
		fl(base_regs_pkg::FOP_POP, 2'h0, 32'hFFFF_FFFF);
		expect32(status_control_word, 32'h0005_7FD7);
		expect32({31'h0, io_direct_ok}, 32'h1);
		string_step <= 1'b1;
		string_size <= base_regs_pkg::OP32;
		fire();
		rd(3'h6, 32'hFFFF_FFFE);
		tick(2);
		expect32({31'h0, irq_accept}, 32'h1);
		fl(base_regs_pkg::FOP_PUSH, 2'h0, 32'h0);
		expect32(saved_image, 32'h0005_7FD7);
		expect32({31'h0, saved_valid}, 32'h1);
		fl(base_regs_pkg::FOP_RET, 2'h0, 32'h0002_0000);
		expect32(status_control_word, 32'h0002_0002);
		expect32({31'h0, ret_to_task}, 32'h1);
		fl(base_regs_pkg::FOP_PUSH, 2'h0, 32'h0);
		expect32(saved_image, 32'h0000_0002);
		fl(base_regs_pkg::FOP_INT, 2'h0, 32'h0);
		expect32(saved_image, 32'h0002_0002);
		priv_op_valid <= 1'b1;
		fire();
		expect32({23'h0, fault_valid, fault_vector}, 32'h0000_010D);
		fl(base_regs_pkg::FOP_TASK, 2'h3, 32'h0004_1000);
		expect32(status_control_word, 32'h0004_1002);
		expect32({31'h0, io_direct_ok}, 32'h0);
	endtask : s_image
	task automatic s_faults;
		mref(base_regs_pkg::MEM_WORD, 3'h1, 1'b0, 2'h3, 1'b1);
		mref(base_regs_pkg::MEM_WORD, 3'h2, 1'b0, 2'h3, 1'b0);
		mref(base_regs_pkg::MEM_DWORD, 3'h2, 1'b0, 2'h3, 1'b1);
		mref(base_regs_pkg::MEM_QWORD, 3'h4, 1'b0, 2'h3, 1'b1);
		mref(base_regs_pkg::MEM_WORD, 3'h1, 1'b1, 2'h3, 1'b0);
		mref(base_regs_pkg::MEM_WORD, 3'h1, 1'b0, 2'h2, 1'b0);
		fl(base_regs_pkg::FOP_TASK, 2'h3, 32'h0001_0100);
		bp_hit <= 1'b1;
		fire();
		expect32({31'h0, fault_valid}, 32'h0);
		instr_done <= 1'b1;
		instr_len <= 4'h1;
		fire();
		expect32({23'h0, fault_valid, fault_vector}, 32'h0000_0101);
	endtask : s_faults

	////////////////////////////////////////////////////////////////////////////////
	// main sequence and verdict
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		tick(4);
		rstn <= 1'b1;
		tick();
		expect32(status_control_word, 32'h0000_0002);
		s_regs();
		s_flags();
		s_image();
		s_faults();
		tally_and_finish();
	end
endmodule : base_register_file_test
